//--- psdl_loader.sv
// port strap default loader with ahb-lite register slave
// assumes a single ahb-lite master, word transfers only, one clock
// Summary of operation
// - port 1 pause strap sets tx and rx
// - pause enables act only under manual select
// - manual strap low: negotiated, symmetric pause advertised
// - manual strap high: manual select, no symmetric pause
// - auto crossover strap rules when override clear
// - override set ignores auto crossover strap
// - manual crossover strap picks straight or crossed
// - negotiation strap sets port 2 enable bit
// - negotiation strap shapes 10 Mbps advert and mode; speed and duplex always set
`timescale 1ns/1ps
`default_nettype none
module psdl_loader (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // strap pins
  input wire psdl_pkg::psdl_strap_s strap_pin_in,
  // negotiated pause result for port 1
  input wire logic p1_neg_tx_pause,
  input wire logic p1_neg_rx_pause,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // effective port state
  output var psdl_pkg::psdl_p1_state_s p1_state,
  output var psdl_pkg::psdl_p2_state_s p2_state
);
  import psdl_pkg::*;

  psdl_strap_s strap_sync; // synced straps
  logic load_pulse; // one-cycle default load

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  psdl_strap_capture u_cap (
    .clk(clk),
    .rstn(rstn),
    .strap_pin_in(strap_pin_in),
    .strap_sync(strap_sync),
    .load_pulse(load_pulse)
  );

  // register file
  logic [2:0] p1_flow_reg, p1_flow_next; // manual pause control
  logic [15:0] p1_adv_reg, p1_adv_next; // port 1 advertisement
  logic [15:0] p2_basic_reg, p2_basic_next; // port 2 basic control
  logic [15:0] p2_adv_reg, p2_adv_next; // port 2 advertisement
  logic [15:0] p2_modes_reg, p2_modes_next; // port 2 special modes
  logic [15:0] p2_xctl_reg, p2_xctl_next; // port 2 crossover control
  psdl_strap_s strap_reg, strap_next; // straps kept for crossover
  // bus pipeline
  logic wr_pend_reg, wr_pend_next; // write data phase pending
  logic [31:0] wr_addr_reg, wr_addr_next; // address of pending write
  logic [31:0] hrdata_reg, hrdata_next; // read data
  // effective outputs
  psdl_p1_state_s p1_state_reg, p1_state_next;
  psdl_p2_state_s p2_state_reg, p2_state_next;
  logic addr_ok; // address phase accepted
  logic [31:0] status_word; // read-only view

  assign addr_ok = hsel && htrans[1] && hready;
  // hsize is not decoded: only whole-word transfers are issued

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  // strap load beats a colliding write; after it only writes change bits
  always_comb begin
    p1_flow_next = p1_flow_reg;
    p1_adv_next = p1_adv_reg;
    p2_basic_next = p2_basic_reg;
    p2_adv_next = p2_adv_reg;
    p2_modes_next = p2_modes_reg;
    p2_xctl_next = p2_xctl_reg;
    strap_next = strap_reg;
    wr_pend_next = addr_ok && hwrite;
    wr_addr_next = haddr;
    if (load_pulse) begin
      strap_next = strap_sync;
      p1_flow_next[P1_TX_BIT] = strap_sync.p1_duplex_pause;
      p1_flow_next[P1_RX_BIT] = strap_sync.p1_duplex_pause;
      p1_flow_next[P1_MAN_BIT] = strap_sync.p1_manual_pause;
      p1_adv_next[ADV_SYM_BIT] = !strap_sync.p1_manual_pause;
      p2_basic_next[BASIC_AN_BIT] = strap_sync.p2_negotiate;
      // forced mode falls back to 100 full without 10 Mbps adverts
      p2_basic_next[BASIC_SPEED_BIT] = 1'b1;
      p2_basic_next[BASIC_DUPLEX_BIT] = 1'b1;
      p2_adv_next[ADV_10FD_BIT] = strap_sync.p2_negotiate;
      p2_adv_next[ADV_10HD_BIT] = strap_sync.p2_negotiate;
      p2_modes_next[MODE_LSB+:3] = strap_sync.p2_negotiate ? MODE_AUTO : MODE_FORCED;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == ADDR_P1_FLOW) begin
        p1_flow_next = hwdata[2:0];
      end else if (wr_addr_reg == ADDR_P1_ADV) begin
        p1_adv_next = hwdata[15:0];
      end else if (wr_addr_reg == ADDR_P2_BASIC) begin
        p2_basic_next = hwdata[15:0];
      end else if (wr_addr_reg == ADDR_P2_ADV) begin
        p2_adv_next = hwdata[15:0];
      end else if (wr_addr_reg == ADDR_P2_MODES) begin
        p2_modes_next = hwdata[15:0];
      end else if (wr_addr_reg == ADDR_P2_XCTL) begin
        p2_xctl_next = hwdata[15:0];
      end
      // other addresses: write ignored
    end
  end

  // ----------------------------------------------------------------
  // effective state and read data
  // ----------------------------------------------------------------
  // read mux looks at next values so a read right after a write sees it
  always_comb begin
    if (p1_flow_reg[P1_MAN_BIT]) begin
      p1_state_next.tx_pause = p1_flow_reg[P1_TX_BIT];
      p1_state_next.rx_pause = p1_flow_reg[P1_RX_BIT];
    end else begin // pause enables ignored here
      p1_state_next.tx_pause = p1_neg_tx_pause;
      p1_state_next.rx_pause = p1_neg_rx_pause;
    end
    p1_state_next.use_negotiated = !p1_flow_reg[P1_MAN_BIT];
    if (p2_xctl_reg[XCTL_OVR_BIT]) begin
      p2_state_next.auto_cross = p2_xctl_reg[XCTL_AUTO_BIT];
      p2_state_next.crossed = p2_xctl_reg[XCTL_CROSS_BIT];
    end else begin
      p2_state_next.auto_cross = strap_reg.p2_auto_cross;
      p2_state_next.crossed = strap_reg.p2_manual_cross;
    end
    p2_state_next.negotiate = p2_basic_reg[BASIC_AN_BIT];
    p2_state_next.speed_100 = p2_basic_reg[BASIC_SPEED_BIT];
    p2_state_next.full_duplex = p2_basic_reg[BASIC_DUPLEX_BIT];
    p2_state_next.mode = p2_modes_reg[MODE_LSB+:3];
    // 22 zero bits + 8 port 2 bits + 2 pause bits fill the word exactly
    status_word = {22'h0, p2_state_next, p1_state_next[2:1]};
    hrdata_next = 32'h0000_0000; // unmapped reads return zero
    if (addr_ok && !hwrite) begin
      if (haddr == ADDR_P1_FLOW) begin
        hrdata_next = {29'h0, p1_flow_next};
      end else if (haddr == ADDR_P1_ADV) begin
        hrdata_next = {16'h0000, p1_adv_next};
      end else if (haddr == ADDR_P2_BASIC) begin
        hrdata_next = {16'h0000, p2_basic_next};
      end else if (haddr == ADDR_P2_ADV) begin
        hrdata_next = {16'h0000, p2_adv_next};
      end else if (haddr == ADDR_P2_MODES) begin
        hrdata_next = {16'h0000, p2_modes_next};
      end else if (haddr == ADDR_P2_XCTL) begin
        hrdata_next = {16'h0000, p2_xctl_next};
      end else if (haddr == ADDR_STATUS) begin
        hrdata_next = status_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // register file resets match the pin defaults; the state outputs reset to fixed 3'h3 and 8'hFF
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p1_flow_reg <= P1_FLOW_RST;
      p1_adv_reg <= P1_ADV_RST;
      p2_basic_reg <= P2_BASIC_RST;
      p2_adv_reg <= P2_ADV_RST;
      p2_modes_reg <= P2_MODES_RST;
      p2_xctl_reg <= P2_XCTL_RST;
      strap_reg <= STRAP_DEFAULT;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      hrdata_reg <= 32'h0000_0000;
      p1_state_reg <= 3'h3;
      p2_state_reg <= 8'hFF;
    end else begin
      p1_flow_reg <= p1_flow_next;
      p1_adv_reg <= p1_adv_next;
      p2_basic_reg <= p2_basic_next;
      p2_adv_reg <= p2_adv_next;
      p2_modes_reg <= p2_modes_next;
      p2_xctl_reg <= p2_xctl_next;
      strap_reg <= strap_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      p1_state_reg <= p1_state_next;
      p2_state_reg <= p2_state_next;
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign p1_state = p1_state_reg;
  assign p2_state = p2_state_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  pause_load_a: assert property (load_pulse |=>
    p1_flow_reg[1:0] == {2{$past(strap_sync.p1_duplex_pause)}})
    else $error("pause enables not loaded from strap");
  manual_gov_a: assert property (p1_flow_reg[P1_MAN_BIT] |=>
    p1_state.tx_pause == $past(p1_flow_reg[P1_TX_BIT]) &&
    p1_state.rx_pause == $past(p1_flow_reg[P1_RX_BIT]))
    else $error("manual pause not followed");
  neg_pause_a: assert property (load_pulse && !strap_sync.p1_manual_pause |=>
    !p1_flow_reg[P1_MAN_BIT] && p1_adv_reg[ADV_SYM_BIT] ##1 p1_state.use_negotiated)
    else $error("negotiated pause default wrong");
  man_pause_a: assert property (load_pulse && strap_sync.p1_manual_pause |=>
    p1_flow_reg[P1_MAN_BIT] && !p1_adv_reg[ADV_SYM_BIT])
    else $error("manual pause default wrong");
  auto_strap_a: assert property (!p2_xctl_reg[XCTL_OVR_BIT] |=>
    p2_state.auto_cross == $past(strap_reg.p2_auto_cross))
    else $error("auto crossover strap not used");
  override_a: assert property (p2_xctl_reg[XCTL_OVR_BIT] |=>
    p2_state.auto_cross == $past(p2_xctl_reg[XCTL_AUTO_BIT]) &&
    p2_state.crossed == $past(p2_xctl_reg[XCTL_CROSS_BIT]))
    else $error("override did not win");
  manual_cross_a: assert property (
    !p2_xctl_reg[XCTL_OVR_BIT] && !strap_reg.p2_auto_cross |=>
    p2_state.crossed == $past(strap_reg.p2_manual_cross))
    else $error("manual crossover wrong");
  neg_enable_a: assert property (load_pulse |=>
    p2_basic_reg[BASIC_AN_BIT] == $past(strap_sync.p2_negotiate) ##1
    p2_state.negotiate == $past(p2_basic_reg[BASIC_AN_BIT]))
    else $error("negotiation enable default wrong");
  mode_shape_a: assert property (load_pulse |=>
    p2_modes_reg[MODE_LSB+:3] == ($past(strap_sync.p2_negotiate) ? MODE_AUTO : MODE_FORCED) &&
    p2_adv_reg[ADV_10HD_BIT] == $past(strap_sync.p2_negotiate) &&
    p2_adv_reg[ADV_10FD_BIT] == $past(strap_sync.p2_negotiate))
    else $error("negotiation side effects wrong");
  write_stick_a: assert property (!load_pulse && !wr_pend_reg |=>
    $stable(p2_basic_reg) && $stable(p1_flow_reg) && $stable(strap_reg))
    else $error("register changed without cause");

endmodule
`default_nettype wire

//--- psdl_pkg.sv
// constants and carriers for the port strap default loader
// assumes one 20 MHz clock domain and word-only ahb-lite accesses
package psdl_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_P1_FLOW = 32'h0000_0000; // port 1 manual pause control
  localparam logic [31:0] ADDR_P1_ADV = 32'h0000_0004; // port 1 advertisement
  localparam logic [31:0] ADDR_P2_BASIC = 32'h0000_0008; // port 2 basic control
  localparam logic [31:0] ADDR_P2_ADV = 32'h0000_000C; // port 2 advertisement
  localparam logic [31:0] ADDR_P2_MODES = 32'h0000_0010; // port 2 special modes
  localparam logic [31:0] ADDR_P2_XCTL = 32'h0000_0014; // port 2 special control/status
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0018; // read-only effective state

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int P1_TX_BIT = 0; // transmit pause enable
  localparam int P1_RX_BIT = 1; // receive pause enable
  localparam int P1_MAN_BIT = 2; // manual pause select
  localparam int ADV_SYM_BIT = 10; // symmetric pause advertised
  localparam int ADV_10FD_BIT = 6; // 10 Mbps full duplex advertised
  localparam int ADV_10HD_BIT = 5; // 10 Mbps half duplex advertised
  localparam int BASIC_SPEED_BIT = 13; // speed select low bit
  localparam int BASIC_AN_BIT = 12; // negotiation enable bit
  localparam int BASIC_DUPLEX_BIT = 8; // duplex select bit
  localparam int MODE_LSB = 5; // special mode field, three bits
  localparam int XCTL_OVR_BIT = 15; // crossover override control
  localparam int XCTL_AUTO_BIT = 14; // auto crossover when overridden
  localparam int XCTL_CROSS_BIT = 13; // crossed wiring when overridden

  // ----------------------------------------------------------------
  // reset values and strap-derived defaults
  // ----------------------------------------------------------------
  localparam logic [4:0] STRAP_DEFAULT = 5'h15; // pin defaults before sampling
  localparam logic [2:0] P1_FLOW_RST = 3'h3; // both pauses on, manual off
  localparam logic [15:0] P1_ADV_RST = 16'h0400; // symmetric pause advertised
  localparam logic [15:0] P2_BASIC_RST = 16'h3100; // negotiation, 100, full
  localparam logic [15:0] P2_ADV_RST = 16'h0060; // both 10 Mbps modes
  localparam logic [15:0] P2_MODES_RST = 16'h00E0; // all-capable mode
  localparam logic [15:0] P2_XCTL_RST = 16'h0000; // override clear
  localparam logic [2:0] MODE_AUTO = 3'h7; // mode with negotiation on
  localparam logic [2:0] MODE_FORCED = 3'h3; // mode with negotiation off
  localparam logic [1:0] CAP_CNT = 2'h1; // count at which the load strobe is set up, so it rises on the same edge that the synced straps become valid
  localparam logic [1:0] CAP_DONE = 2'h2; // counter saturation value

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic p2_negotiate; // port 2 negotiation strap
    logic p2_manual_cross; // port 2 manual crossover strap
    logic p2_auto_cross; // port 2 auto crossover strap
    logic p1_manual_pause; // port 1 manual pause strap
    logic p1_duplex_pause; // port 1 full-duplex pause strap
  } psdl_strap_s;

  typedef struct packed {
    logic tx_pause; // transmit pause in effect
    logic rx_pause; // receive pause in effect
    logic use_negotiated; // pause follows negotiation result
  } psdl_p1_state_s;

  typedef struct packed {
    logic auto_cross; // automatic crossover running
    logic crossed; // crossed wiring when not automatic
    logic negotiate; // negotiation enabled
    logic speed_100; // speed select low bit
    logic full_duplex; // duplex select bit
    logic [2:0] mode; // special mode field
  } psdl_p2_state_s;

endpackage

//--- psdl_strap_capture.sv
// strap synchroniser and one-shot load strobe
// assumes strap pins are asynchronous and steady around reset release
`timescale 1ns/1ps
`default_nettype none
module psdl_strap_capture (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // strap pins
  input wire psdl_pkg::psdl_strap_s strap_pin_in,
  // synced straps and load strobe
  output var psdl_pkg::psdl_strap_s strap_sync,
  output logic load_pulse
);
  import psdl_pkg::*;

  psdl_strap_s meta_reg, meta_next; // first stage, read only by second
  psdl_strap_s sync_reg, sync_next; // second stage
  logic [1:0] cnt_reg, cnt_next; // cycles since release
  logic load_reg, load_next; // single load strobe

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the strobe waits until the second stage holds real pin levels
  always_comb begin
    meta_next = strap_pin_in;
    sync_next = meta_reg;
    cnt_next = (cnt_reg == CAP_DONE) ? cnt_reg : cnt_reg + 2'h1;
    load_next = (cnt_reg == CAP_CNT);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset takes the pin defaults, never the pins themselves
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= STRAP_DEFAULT;
      sync_reg <= STRAP_DEFAULT;
      cnt_reg <= 2'h0;
      load_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      cnt_reg <= cnt_next;
      load_reg <= load_next;
    end
  end

  assign strap_sync = sync_reg;
  assign load_pulse = load_reg;

endmodule
`default_nettype wire

//--- psdl_pkg_end.sv
// empty source file: holds no declarations
// assumes nothing of its surroundings

//--- psdl_strap_model.sv
// far-side model: strap pin drivers and the negotiated pause result
// assumes the bench sets strap_cfg and neg_cfg just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module psdl_strap_model (
  // clock
  input wire logic clk,
  // wanted pin levels
  input wire psdl_pkg::psdl_strap_s strap_cfg,
  input wire logic [1:0] neg_cfg,
  // pins seen by the loader
  output var psdl_pkg::psdl_strap_s strap_pin_in,
  output logic neg_tx,
  output logic neg_rx
);
  import psdl_pkg::*;

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // straps are resistor levels, so they follow the setting at once
  always_comb begin
    strap_pin_in = strap_cfg; // strap levels as wired
  end

  // negotiation result comes from same-clock logic, so it moves on the edge
  always_ff @(posedge clk) begin
    neg_tx <= neg_cfg[1]; // partner link grants tx pause
    neg_rx <= neg_cfg[0]; // partner link grants rx pause
  end
endmodule
`default_nettype wire

//--- psdl_loader_tb.sv
// self-checking bench for the strap default loader
// assumes one slave on ahb-lite, zero wait answers, 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module psdl_loader_tb;
  import psdl_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, ntx, nrx;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, ncfg;
  logic [2:0] hsize;
  psdl_strap_s pins, cfg; // pin levels and wanted levels
  psdl_p1_state_s p1_state;
  psdl_p2_state_s p2_state;
  int n_mismatch = 0;
  int n_compared = 0;

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  psdl_strap_model model (.clk(clk), .strap_cfg(cfg), .neg_cfg(ncfg),
    .strap_pin_in(pins), .neg_tx(ntx), .neg_rx(nrx));

  psdl_loader uut (.clk(clk), .rstn(rstn), .strap_pin_in(pins),
    .p1_neg_tx_pause(ntx), .p1_neg_rx_pause(nrx), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .p1_state(p1_state),
    .p2_state(p2_state));

  // ------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // whole run is under a hundred cycles, so 4000 means a hang
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // outputs lag the register by one edge, so let two pass
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // straps stay steady through reset and the load that follows it
  task automatic do_reset(input psdl_strap_s s, input logic [1:0] n);
    cfg <= s;
    ncfg <= n;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cfg = STRAP_DEFAULT;
    ncfg = 2'h2;
    // pin defaults, negotiated tx only
    do_reset(STRAP_DEFAULT, 2'h2);
    rd_chk(ADDR_P1_FLOW, 32'h3);
    rd_chk(ADDR_P1_ADV, 32'h400);
    rd_chk(ADDR_P2_BASIC, 32'h3100);
    rd_chk(ADDR_P2_ADV, 32'h60);
    rd_chk(ADDR_P2_MODES, 32'hE0);
    rd_chk(ADDR_STATUS, 32'h2FE);
    chk({29'h0, p1_state}, 32'h5);
    chk({24'h0, p2_state}, 32'hBF);
    rd_chk(32'h40, 32'h0);
    $display("test pin defaults done");
    // every strap flipped, negotiation grants both pauses
    do_reset(5'h0A, 2'h3);
    rd_chk(ADDR_P1_FLOW, 32'h4);
    rd_chk(ADDR_P1_ADV, 32'h0);
    rd_chk(ADDR_P2_BASIC, 32'h2100);
    rd_chk(ADDR_P2_ADV, 32'h0);
    rd_chk(ADDR_P2_MODES, 32'h60);
    chk({29'h0, p1_state}, 32'h0);
    chk({24'h0, p2_state}, 32'h5B);
    wr(ADDR_P1_FLOW, 32'h5);
    wr(ADDR_P2_XCTL, 32'h8000);
    settle;
    chk({29'h0, p1_state}, 32'h4);
    chk({24'h0, p2_state}, 32'h1B);
    wr(ADDR_P2_XCTL, 32'hC000);
    settle;
    chk({24'h0, p2_state}, 32'h9B);
    $display("test flipped straps done");
    // software values stick when the pins move after reset
    wr(ADDR_P2_BASIC, 32'h1100);
    cfg <= STRAP_DEFAULT;
    repeat (8) @(posedge clk);
    rd_chk(ADDR_P2_BASIC, 32'h1100);
    rd_chk(ADDR_P1_FLOW, 32'h5);
    wr(ADDR_P2_XCTL, 32'h0);
    settle;
    chk({30'h0, p2_state[7:6]}, 32'h1);
    $display("test sticky writes done");
    // straight wiring, pauses off, negotiation grants rx pause only
    do_reset(5'h10, 2'h1);
    rd_chk(ADDR_P1_FLOW, 32'h0);
    rd_chk(ADDR_P1_ADV, 32'h400);
    chk({30'h0, p2_state[7:6]}, 32'h0);
    chk({29'h0, p1_state}, 32'h3);
    rd_chk(ADDR_STATUS, 32'hFD);
    $display("test straight wiring done");
    end_of_test;
  end
endmodule
`default_nettype wire
